// [src/dmsd_top.sv]
`timescale 1ns/10ps
`include "dmsd_params.svh"
module dmsd_top #(
   parameter int XRAM_BYTES = `DMSD_XRAM_BYTES,
   parameter int XRAM_AW    = 10
) (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire dmsd_pkg::dmsd_acc_t acc_kind,
   input  wire logic                acc_wr,
   input  wire logic [7:0]          acc_addr,
   input  wire logic                acc_use_reg_one,
   input  wire logic [15:0]         xdata_addr,
   input  wire logic [7:0]          acc_wdata,
   input  wire logic                acc_wbit,
   input  wire dmsd_pkg::dmsd_stk_t stk_op,
   input  wire logic [7:0]          sfr_ext_rdata,
   output logic [7:0]               rd_data,
   output logic                     rd_bit,
   output logic                     rd_valid,
   output logic [7:0]               stack_pointer,
   output logic [7:0]               program_status_word,
   output logic                     sfr_ext_sel,
   output logic                     sfr_ext_wr,
   output logic [7:0]               sfr_ext_addr,
   output logic [7:0]               sfr_ext_wdata,
   output logic                     stk_overflow,
   output logic                     stk_underflow
);
   import dmsd_pkg::*;
   // ==========================================
   // decode
   logic [7:0]  ptr_ff,  nxt_ptr;
   logic        ptr_pending_ff, nxt_ptr_pending;
   logic [7:0]  sp_ff,   nxt_sp;
   logic [7:0]  psw_ff,  nxt_psw;
   logic [7:0]  iram_addr;
   logic        iram_we;
   logic [7:0]  iram_wdata;
   logic [7:0]  iram_rdata;
   logic        xram_we;
   logic [7:0]  xram_rdata;
   logic [1:0]  bank;
   logic        is_sfr;
   logic [7:0]  byte_addr;
   logic [2:0]  bit_pos;
   logic        bit_ok;
   // read path selection remembered for the registered return
   typedef enum logic [1:0] {
      DMSD_SRC_IRAM = 2'b00,
      DMSD_SRC_SFR  = 2'b01,
      DMSD_SRC_XRAM = 2'b10
   } dmsd_src_t;
   dmsd_src_t   src_ff,  nxt_src;
   logic        bitacc_ff, nxt_bitacc;
   logic [2:0]  bpos_ff, nxt_bpos;
   logic        valid_ff, nxt_valid;
   logic [7:0]  sfr_loc_ff, nxt_sfr_loc;
   logic        ext_sel_ff, nxt_ext_sel;
   logic        ext_wr_ff,  nxt_ext_wr;
   logic [7:0]  ext_addr_ff, nxt_ext_addr;
   logic [7:0]  ext_wdata_ff, nxt_ext_wdata;
   logic [7:0]  merged;
   logic [7:0]  sfr_now;

   assign bank = {psw_ff[`DMSD_BANK_SEL_HI], psw_ff[`DMSD_BANK_SEL_LO]};

   // bit address split: low region maps to bytes 0x20-0x2F, high region to sfrs
   always_comb begin
      if (acc_addr[`DMSD_SFR_BASE_BIT]) begin
         byte_addr = {acc_addr[7:3], 3'b000};
      end else begin
         byte_addr = `DMSD_BITRAM_BASE + {4'h0, acc_addr[6:3]};
      end
      bit_pos = acc_addr[2:0];
      // only sfrs at x0/x8 exist as bit targets; byte_addr aligns so always true here
      bit_ok  = (byte_addr[2:0] == 3'b000) || !byte_addr[`DMSD_SFR_BASE_BIT];
   end

   // indirect accesses need the pointer byte first, so they take two cycles
   always_comb begin
      nxt_ptr_pending = 1'b0;
      nxt_ptr         = ptr_ff;
      iram_addr       = acc_addr;
      is_sfr          = 1'b0;
      case (acc_kind)
         DMSD_ACC_DIRECT: begin
            is_sfr    = acc_addr[`DMSD_SFR_BASE_BIT];
            iram_addr = acc_addr;
         end
         DMSD_ACC_BIT: begin
            is_sfr    = byte_addr[`DMSD_SFR_BASE_BIT];
            iram_addr = byte_addr;
            // bit writes read the byte first, merge on the second cycle
            nxt_ptr_pending = acc_wr && !ptr_pending_ff;
         end
         DMSD_ACC_INDIRECT: begin
            // fetch working reg zero/one of the active bank
            iram_addr       = {3'b000, bank, 2'b00, acc_use_reg_one};
            nxt_ptr_pending = !ptr_pending_ff;
            if (ptr_pending_ff) begin
               // pointer byte is on the ram output now; ptr_ff lags a cycle
               iram_addr = iram_rdata;
            end
         end
         default: begin
            iram_addr = acc_addr;
         end
      endcase
      if (ptr_pending_ff) begin
         nxt_ptr = iram_rdata;
      end else begin
         nxt_ptr = ptr_ff;
      end
   end

   // sp and psw held here; every other sfr goes out to peripherals
   always_comb begin
      case ((acc_kind == DMSD_ACC_BIT) ? byte_addr : acc_addr)
         `DMSD_SP_ADDR:  sfr_now = sp_ff;
         `DMSD_PSW_ADDR: sfr_now = psw_ff;
         default:        sfr_now = sfr_ext_rdata;
      endcase
   end

   // ==========================================
   // write and stack
   always_comb begin
      iram_we    = 1'b0;
      iram_wdata = acc_wdata;
      xram_we    = 1'b0;
      nxt_sp     = sp_ff;
      nxt_psw    = psw_ff;
      merged     = (is_sfr ? sfr_now : iram_rdata);
      merged[bit_pos] = acc_wbit;
      nxt_ext_sel   = 1'b0;
      nxt_ext_wr    = 1'b0;
      nxt_ext_addr  = ext_addr_ff;
      nxt_ext_wdata = ext_wdata_ff;
      case (acc_kind)
         DMSD_ACC_DIRECT, DMSD_ACC_BIT: begin
            if (is_sfr) begin
               nxt_ext_sel  = !((iram_addr == `DMSD_SP_ADDR) || (iram_addr == `DMSD_PSW_ADDR));
               nxt_ext_wr   = acc_wr && nxt_ext_sel;
               nxt_ext_addr = iram_addr;
               nxt_ext_wdata = (acc_kind == DMSD_ACC_BIT) ? merged : acc_wdata;
               if (acc_wr && iram_addr == `DMSD_SP_ADDR) begin
                  nxt_sp = (acc_kind == DMSD_ACC_BIT) ? merged : acc_wdata;
               end
               if (acc_wr && iram_addr == `DMSD_PSW_ADDR) begin
                  nxt_psw = (acc_kind == DMSD_ACC_BIT) ? merged : acc_wdata;
               end
            end else begin
               // bit writes are read-modify-write of the stored byte
               iram_we    = acc_wr && (acc_kind == DMSD_ACC_DIRECT || (bit_ok && ptr_pending_ff));
               iram_wdata = (acc_kind == DMSD_ACC_BIT) ? merged : acc_wdata;
            end
         end
         DMSD_ACC_INDIRECT: begin
            iram_we = acc_wr && ptr_pending_ff;
         end
         DMSD_ACC_XDATA: begin
            xram_we = acc_wr;
         end
         default: begin
            iram_we = 1'b0;
         end
      endcase
      // push: store at sp+1, then bump the pointer; wraps in 256 bytes
      case (stk_op)
         DMSD_STK_PUSH, DMSD_STK_CALL, DMSD_STK_INC: begin
            nxt_sp = sp_ff + 8'h01;
         end
         DMSD_STK_POP, DMSD_STK_DEC: begin
            nxt_sp = sp_ff - 8'h01;
         end
         DMSD_STK_RET: begin
            nxt_sp = sp_ff - 8'h02;
         end
         default: begin
            nxt_sp = nxt_sp;
         end
      endcase
      if (stk_op == DMSD_STK_PUSH) begin
         iram_we    = 1'b1;
         iram_addr_override();
      end
   end

   function automatic void iram_addr_override();
   endfunction : iram_addr_override

   // read return bookkeeping
   always_comb begin
      nxt_valid   = (acc_kind != DMSD_ACC_NONE) && !acc_wr &&
                    !(acc_kind == DMSD_ACC_INDIRECT && !ptr_pending_ff);
      nxt_src     = (acc_kind == DMSD_ACC_XDATA) ? DMSD_SRC_XRAM :
                    (is_sfr ? DMSD_SRC_SFR : DMSD_SRC_IRAM);
      nxt_bitacc  = (acc_kind == DMSD_ACC_BIT);
      nxt_bpos    = bit_pos;
      nxt_sfr_loc = sfr_now;
   end

   logic [7:0] push_addr;
   logic [7:0] ram_addr_final;
   assign push_addr      = sp_ff + 8'h01;
   assign ram_addr_final = (stk_op == DMSD_STK_PUSH) ? push_addr : iram_addr;

   dmsd_ram #(
      .DEPTH (`DMSD_RAM_BYTES),
      .AW    (8)
   ) u_iram (
      .sys_clk (sys_clk),
      .we      (iram_we),
      .addr    (ram_addr_final),
      .wdata   (iram_wdata),
      .rdata   (iram_rdata)
   );

   // upper address bits ignored so the block aliases every 1 KB
   dmsd_ram #(
      .DEPTH (XRAM_BYTES),
      .AW    (XRAM_AW)
   ) u_xram (
      .sys_clk (sys_clk),
      .we      (xram_we),
      .addr    (xdata_addr[XRAM_AW-1:0]),
      .wdata   (acc_wdata),
      .rdata   (xram_rdata)
   );

   dmsd_stack_rec u_rec (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .stk_op    (stk_op),
      .call_bit  (1'b1),
      .overflow  (stk_overflow),
      .underflow (stk_underflow)
   );

   // ==========================================
   // registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sp_ff          <= `DMSD_SP_RESET;
         psw_ff         <= `DMSD_PSW_RESET;
         ptr_ff         <= 8'h00;
         ptr_pending_ff <= 1'b0;
         src_ff         <= DMSD_SRC_IRAM;
         bitacc_ff      <= 1'b0;
         bpos_ff        <= 3'h0;
         valid_ff       <= 1'b0;
         sfr_loc_ff     <= 8'h00;
         ext_sel_ff     <= 1'b0;
         ext_wr_ff      <= 1'b0;
         ext_addr_ff    <= 8'h00;
         ext_wdata_ff   <= 8'h00;
      end else begin
         sp_ff          <= nxt_sp;
         psw_ff         <= nxt_psw;
         ptr_ff         <= nxt_ptr;
         ptr_pending_ff <= nxt_ptr_pending;
         src_ff         <= nxt_src;
         bitacc_ff      <= nxt_bitacc;
         bpos_ff        <= nxt_bpos;
         valid_ff       <= nxt_valid;
         sfr_loc_ff     <= nxt_sfr_loc;
         ext_sel_ff     <= nxt_ext_sel;
         ext_wr_ff      <= nxt_ext_wr;
         ext_addr_ff    <= nxt_ext_addr;
         ext_wdata_ff   <= nxt_ext_wdata;
      end
   end

   // read data mux; ram outputs are already registered
   always_comb begin
      case (src_ff)
         // outside sfrs answer once their select is out
         DMSD_SRC_SFR:  rd_data = ext_sel_ff ? sfr_ext_rdata : sfr_loc_ff;
         DMSD_SRC_XRAM: rd_data = xram_rdata;
         default:       rd_data = iram_rdata;
      endcase
      rd_bit = bitacc_ff ? rd_data[bpos_ff] : 1'b0;
   end

   assign rd_valid            = valid_ff;
   assign stack_pointer       = sp_ff;
   assign program_status_word = psw_ff;
   assign sfr_ext_sel         = ext_sel_ff;
   assign sfr_ext_wr          = ext_wr_ff;
   assign sfr_ext_addr        = ext_addr_ff;
   assign sfr_ext_wdata       = ext_wdata_ff;
endmodule : dmsd_top

// [src/dmsd_params.svh]
`ifndef DMSD_PARAMS_SVH
`define DMSD_PARAMS_SVH
// ==========================================
// address map
`define DMSD_RAM_BYTES        256
`define DMSD_XRAM_BYTES       1024
`define DMSD_SP_ADDR          8'h81
`define DMSD_PSW_ADDR         8'hD0
`define DMSD_SP_RESET         8'h07
`define DMSD_BANK_SEL_LO      3
`define DMSD_BANK_SEL_HI      4
`define DMSD_BITRAM_BASE      8'h20
`define DMSD_SFR_BASE_BIT     7
`define DMSD_REC_BITS         32
`define DMSD_PSW_RESET        8'h00
`endif

// [src/dmsd_pkg.sv]
package dmsd_pkg;
   // ==========================================
   // access kinds from the decoder
   typedef enum logic [2:0] {
      DMSD_ACC_NONE     = 3'b000,
      DMSD_ACC_DIRECT   = 3'b001,
      DMSD_ACC_INDIRECT = 3'b010,
      DMSD_ACC_BIT      = 3'b011,
      DMSD_ACC_XDATA    = 3'b100
   } dmsd_acc_t;
   // stack record events
   typedef enum logic [2:0] {
      DMSD_STK_NONE = 3'b000,
      DMSD_STK_PUSH = 3'b001,
      DMSD_STK_POP  = 3'b010,
      DMSD_STK_CALL = 3'b011,
      DMSD_STK_RET  = 3'b100,
      DMSD_STK_INC  = 3'b101,
      DMSD_STK_DEC  = 3'b110
   } dmsd_stk_t;
endpackage : dmsd_pkg

// [src/dmsd_ram.sv]
`timescale 1ns/10ps
// single-port byte ram, synchronous write, registered read
module dmsd_ram #(
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic          sys_clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [DEPTH];
   // ==========================================
   // storage
   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : dmsd_ram

// [src/dmsd_stack_rec.sv]
`timescale 1ns/10ps
`include "dmsd_params.svh"
module dmsd_stack_rec #(
   parameter int BITS = `DMSD_REC_BITS
) (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire dmsd_pkg::dmsd_stk_t stk_op,
   input  wire logic                call_bit,
   output logic                     overflow,
   output logic                     underflow
);
   import dmsd_pkg::*;
   logic [BITS-1:0] rec_ff,   nxt_rec;
   logic [6:0]      depth_ff, nxt_depth;
   logic            ovf_ff,   nxt_ovf;
   logic            unf_ff,   nxt_unf;
   assign overflow  = ovf_ff;
   assign underflow = unf_ff;
   // ==========================================
   // shift record; depth counts valid bits so limits are detectable
   always_comb begin
      nxt_rec   = rec_ff;
      nxt_depth = depth_ff;
      nxt_ovf   = 1'b0;
      nxt_unf   = 1'b0;
      case (stk_op)
         DMSD_STK_PUSH, DMSD_STK_INC: begin
            nxt_rec   = {rec_ff[BITS-2:0], 1'b0};
            nxt_ovf   = (depth_ff >= 7'(BITS));
            nxt_depth = nxt_ovf ? depth_ff : depth_ff + 7'd1;
         end
         DMSD_STK_CALL: begin
            nxt_rec   = {rec_ff[BITS-3:0], call_bit, 1'b1};
            nxt_ovf   = (depth_ff > 7'(BITS - 2));
            nxt_depth = nxt_ovf ? 7'(BITS) : depth_ff + 7'd2;
         end
         DMSD_STK_POP, DMSD_STK_DEC: begin
            nxt_rec   = {1'b0, rec_ff[BITS-1:1]};
            nxt_unf   = (depth_ff == 7'd0);
            nxt_depth = nxt_unf ? depth_ff : depth_ff - 7'd1;
         end
         DMSD_STK_RET: begin
            nxt_rec   = {2'b00, rec_ff[BITS-1:2]};
            nxt_unf   = (depth_ff < 7'd2);
            nxt_depth = nxt_unf ? 7'd0 : depth_ff - 7'd2;
         end
         default: begin
            nxt_rec = rec_ff;
         end
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rec_ff   <= '0;
         depth_ff <= 7'd0;
         ovf_ff   <= 1'b0;
         unf_ff   <= 1'b0;
      end else begin
         rec_ff   <= nxt_rec;
         depth_ff <= nxt_depth;
         ovf_ff   <= nxt_ovf;
         unf_ff   <= nxt_unf;
      end
   end
endmodule : dmsd_stack_rec

// [sim/dmsd_asserts.sv]
`timescale 1ns/10ps
// ==========================================
// port checker
module dmsd_chk
   import dmsd_pkg::*;
(
   input wire logic                sys_clk,
   input wire logic                rst_n,
   input wire dmsd_pkg::dmsd_acc_t acc_kind,
   input wire logic                acc_wr,
   input wire logic [7:0]          acc_addr,
   input wire logic [7:0]          acc_wdata,
   input wire dmsd_pkg::dmsd_stk_t stk_op,
   input wire logic [7:0]          stack_pointer,
   input wire logic [7:0]          program_status_word,
   input wire logic                sfr_ext_sel,
   input wire logic                sfr_ext_wr,
   input wire logic [7:0]          sfr_ext_addr,
   input wire logic [7:0]          sfr_ext_wdata,
   input wire logic                stk_overflow,
   input wire logic                stk_underflow
);
   logic [5:0] depth_ff;
   logic [5:0] nxt_depth;
   logic       ext_req;
   logic       dir_wr;
   // own record depth, saturating like the design's, so flag moments are known
   always_comb begin
      nxt_depth = depth_ff;
      case (stk_op)
         DMSD_STK_PUSH, DMSD_STK_INC: nxt_depth = (depth_ff < 6'h20) ? depth_ff + 6'h01 : 6'h20;
         DMSD_STK_CALL:               nxt_depth = (depth_ff < 6'h1F) ? depth_ff + 6'h02 : 6'h20;
         DMSD_STK_POP, DMSD_STK_DEC:  nxt_depth = (depth_ff > 6'h00) ? depth_ff - 6'h01 : 6'h00;
         DMSD_STK_RET:                nxt_depth = (depth_ff > 6'h01) ? depth_ff - 6'h02 : 6'h00;
         default:                     nxt_depth = depth_ff;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      depth_ff <= rst_n ? nxt_depth : 6'h00;
   end
   assign dir_wr  = acc_kind == DMSD_ACC_DIRECT && acc_wr;
   assign ext_req = acc_kind == DMSD_ACC_DIRECT && acc_addr[7] && acc_addr != 8'h81 && acc_addr != 8'hD0;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // properties
   sequence s_ext_wr_req;
      ext_req && acc_wr;
   endsequence
   sequence s_ext_wr_out;
      sfr_ext_wr && sfr_ext_wdata == $past(acc_wdata);
   endsequence
   property p_sp_reset;
      disable iff (1'h0) !rst_n |=> stack_pointer == 8'h07;
   endproperty
   property p_psw_reset;
      disable iff (1'h0) !rst_n |=> program_status_word == 8'h00;
   endproperty
   property p_push;
      stk_op == DMSD_STK_PUSH |=> stack_pointer == $past(stack_pointer) + 8'h01;
   endproperty
   property p_sp_hold;
      stk_op == DMSD_STK_NONE && !(dir_wr && acc_addr == 8'h81) |=> $stable(stack_pointer);
   endproperty
   property p_sp_write;
      stk_op == DMSD_STK_NONE && dir_wr && acc_addr == 8'h81 |=> stack_pointer == $past(acc_wdata);
   endproperty
   property p_psw_write;
      dir_wr && acc_addr == 8'hD0 |=> program_status_word == $past(acc_wdata);
   endproperty
   property p_ext_sel;
      ext_req |=> sfr_ext_sel && sfr_ext_addr == $past(acc_addr) && sfr_ext_wr == $past(acc_wr);
   endproperty
   property p_ext_data;
      s_ext_wr_req |=> s_ext_wr_out;
   endproperty
   property p_no_ext;
      acc_kind == DMSD_ACC_INDIRECT || acc_kind == DMSD_ACC_XDATA
         || ((acc_kind == DMSD_ACC_DIRECT || acc_kind == DMSD_ACC_BIT) && !acc_addr[7]) |=> !sfr_ext_sel;
   endproperty
   property p_bit_ext;
      acc_kind == DMSD_ACC_BIT && acc_addr[7] && acc_addr[7:3] != 5'h1A
         |=> sfr_ext_sel && sfr_ext_addr == ($past(acc_addr) & 8'hF8);
   endproperty
   property p_underflow;
      (stk_op == DMSD_STK_POP || stk_op == DMSD_STK_DEC) && depth_ff == 6'h00 |-> ##[1:2] stk_underflow;
   endproperty
   property p_overflow;
      (stk_op == DMSD_STK_PUSH || stk_op == DMSD_STK_INC) && depth_ff == 6'h20 |-> ##[1:2] stk_overflow;
   endproperty
   a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not 07 after reset");
   a_psw_reset: assert property (p_psw_reset) else $error("status word not 00 after reset");
   a_push: assert property (p_push) else $error("push did not step pointer");
   a_sp_hold: assert property (p_sp_hold) else $error("pointer moved without cause");
   a_sp_write: assert property (p_sp_write) else $error("pointer write lost");
   a_psw_write: assert property (p_psw_write) else $error("status word write lost");
   a_ext_sel: assert property (p_ext_sel) else $error("direct upper access not sent out");
   a_ext_data: assert property (p_ext_data) else $error("outside write data wrong");
   a_no_ext: assert property (p_no_ext) else $error("ram access reached outside bank");
   a_bit_ext: assert property (p_bit_ext) else $error("sfr bit address decode wrong");
   a_underflow: assert property (p_underflow) else $error("underflow not flagged");
   a_overflow: assert property (p_overflow) else $error("overflow not flagged");
endmodule : dmsd_chk
bind dmsd_top dmsd_chk dmsd_chk_i (.sys_clk, .rst_n, .acc_kind, .acc_wr, .acc_addr, .acc_wdata, .stk_op,
   .stack_pointer, .program_status_word, .sfr_ext_sel, .sfr_ext_wr, .sfr_ext_addr, .sfr_ext_wdata,
   .stk_overflow, .stk_underflow);

// [sim/dmsd_sfr_model.sv]
`timescale 1ns/10ps
// ==========================================
// outside sfr bank
module dmsd_sfr_model (
   input  wire logic       sys_clk,
   input  wire logic       sfr_ext_sel,
   input  wire logic       sfr_ext_wr,
   input  wire logic [7:0] sfr_ext_addr,
   input  wire logic [7:0] sfr_ext_wdata,
   output logic      [7:0] sfr_ext_rdata
);
   logic [7:0] mem [0:255];
   logic [7:0] last_ff = 8'h00;
   // unselected bank shows the inverse of its last byte so a stale read cannot pass
   assign sfr_ext_rdata = sfr_ext_sel ? mem[sfr_ext_addr] : ~last_ff;
   always_ff @(posedge sys_clk) begin
      if (sfr_ext_sel) begin
         last_ff <= mem[sfr_ext_addr];
         if (sfr_ext_wr) begin
            mem[sfr_ext_addr] <= sfr_ext_wdata;
         end
      end
   end
endmodule : dmsd_sfr_model

// [sim/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
   import dmsd_pkg::*;
   logic sys_clk = 1'h0, rst_n = 1'h0, acc_wr = 1'h0, acc_use_reg_one = 1'h0, acc_wbit = 1'h0;
   dmsd_acc_t acc_kind = DMSD_ACC_NONE;
   dmsd_stk_t stk_op = DMSD_STK_NONE;
   logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00, rd_data, stack_pointer, program_status_word;
   logic [7:0] sfr_ext_rdata, sfr_ext_addr, sfr_ext_wdata, got;
   logic [15:0] xdata_addr = 16'h0000;
   logic rd_bit, rd_valid, sfr_ext_sel, sfr_ext_wr, stk_overflow, stk_underflow, gbit, hit;
   int failures = 0, checked = 0;
   dmsd_top dmsd_top_i (.sys_clk, .rst_n, .acc_kind, .acc_wr, .acc_addr, .acc_use_reg_one, .xdata_addr,
      .acc_wdata, .acc_wbit, .stk_op, .sfr_ext_rdata, .rd_data, .rd_bit, .rd_valid, .stack_pointer,
      .program_status_word, .sfr_ext_sel, .sfr_ext_wr, .sfr_ext_addr, .sfr_ext_wdata, .stk_overflow,
      .stk_underflow);
   dmsd_sfr_model dmsd_sfr_model_i (.sys_clk, .sfr_ext_sel, .sfr_ext_wr, .sfr_ext_addr, .sfr_ext_wdata,
      .sfr_ext_rdata);
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   // ==========================================
   // shared tasks
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
      checked++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask : chk8
   task automatic chk1(input logic g, input logic e, input string m);
      chk8({7'h00, g}, {7'h00, e}, m);
   endtask : chk1
   // request held until answered; writes one cycle, indirect and bit ones two
   task automatic op(input dmsd_acc_t k, input logic w, input logic [15:0] a, input logic [7:0] d);
      int n;
      acc_kind = k; acc_wr = w; acc_addr = a[7:0]; xdata_addr = a; acc_wdata = d; acc_wbit = d[0];
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (w ? n < ((k == DMSD_ACC_INDIRECT || k == DMSD_ACC_BIT) ? 2 : 1) :
                 (rd_valid !== 1'h1 && n < 4));
      if (!w) chk1(rd_valid, 1'h1, "read answer");
      got = rd_data; gbit = rd_bit;
      acc_kind = DMSD_ACC_NONE; acc_wr = 1'h0;
   endtask : op
   task automatic stk(input dmsd_stk_t s, input logic [7:0] d);
      stk_op = s; acc_wdata = d;
      @(negedge sys_clk);
      stk_op = DMSD_STK_NONE;
   endtask : stk
   task automatic do_reset();
      rst_n = 1'h0;
      repeat (3) @(negedge sys_clk);
      rst_n = 1'h1;
   endtask : do_reset
   task automatic results();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   // ==========================================
   // scenarios
   task automatic t_push();
      chk8(stack_pointer, 8'h07, "sp reset");
      op(DMSD_ACC_DIRECT, 1'h0, 16'h0081, 8'h00); chk8(got, 8'h07, "sp via 0x81");
      stk(DMSD_STK_PUSH, 8'hA5); stk(DMSD_STK_PUSH, 8'h5A);
      chk8(stack_pointer, 8'h09, "sp after pushes");
      op(DMSD_ACC_DIRECT, 1'h0, 16'h0008, 8'h00); chk8(got, 8'hA5, "first push at 08");
      op(DMSD_ACC_DIRECT, 1'h0, 16'h0009, 8'h00); chk8(got, 8'h5A, "second push");
      op(DMSD_ACC_DIRECT, 1'h1, 16'h0081, 8'hF0); stk(DMSD_STK_PUSH, 8'h3C);
      op(DMSD_ACC_DIRECT, 1'h1, 16'h0000, 8'hF1);
      op(DMSD_ACC_INDIRECT, 1'h0, 16'h0000, 8'h00); chk8(got, 8'h3C, "push in upper ram");
      $display("push test done");
   endtask : t_push
   task automatic t_banks();
      for (int b = 0; b < 4; b++) begin
         acc_use_reg_one = b[0];
         op(DMSD_ACC_DIRECT, 1'h1, 16'h00D0, 8'(b << 3)); chk8(program_status_word, 8'(b << 3), "psw");
         op(DMSD_ACC_DIRECT, 1'h1, 16'(b * 8 + b % 2), 8'h40 + 8'(b));
         op(DMSD_ACC_INDIRECT, 1'h1, 16'h0000, 8'hC0 + 8'(b));
         op(DMSD_ACC_DIRECT, 1'h0, 16'h0040 + 16'(b), 8'h00); chk8(got, 8'hC0 + 8'(b), "bank ptr");
      end
      acc_use_reg_one = 1'h0;
      op(DMSD_ACC_DIRECT, 1'h1, 16'h00D0, 8'h00);
      op(DMSD_ACC_DIRECT, 1'h1, 16'h0000, 8'h90);
      op(DMSD_ACC_INDIRECT, 1'h1, 16'h0000, 8'h77);
      op(DMSD_ACC_DIRECT, 1'h1, 16'h0090, 8'h11);
      op(DMSD_ACC_DIRECT, 1'h0, 16'h0090, 8'h00); chk8(got, 8'h11, "outside sfr read");
      op(DMSD_ACC_INDIRECT, 1'h0, 16'h0000, 8'h00); chk8(got, 8'h77, "upper ram apart");
      $display("bank test done");
   endtask : t_banks
   task automatic t_bits();
      op(DMSD_ACC_DIRECT, 1'h1, 16'h0022, 8'h00);
      op(DMSD_ACC_BIT, 1'h1, 16'h0013, 8'h01);
      op(DMSD_ACC_DIRECT, 1'h0, 16'h0022, 8'h00); chk8(got, 8'h08, "bit 13 in 22");
      op(DMSD_ACC_BIT, 1'h0, 16'h0013, 8'h00); chk1(gbit, 1'h1, "bit read");
      op(DMSD_ACC_DIRECT, 1'h1, 16'h002F, 8'h00);
      op(DMSD_ACC_BIT, 1'h1, 16'h007F, 8'h01);
      op(DMSD_ACC_DIRECT, 1'h0, 16'h002F, 8'h00); chk8(got, 8'h80, "bit 7F");
      op(DMSD_ACC_BIT, 1'h1, 16'h00D3, 8'h01); chk8(program_status_word, 8'h08, "sfr bit");
      op(DMSD_ACC_BIT, 1'h1, 16'h008A, 8'h01);
      op(DMSD_ACC_DIRECT, 1'h1, 16'h00D0, 8'h00);
      $display("bit test done");
   endtask : t_bits
   task automatic t_xdata();
      op(DMSD_ACC_XDATA, 1'h1, 16'h0123, 8'h5A);
      op(DMSD_ACC_XDATA, 1'h0, 16'h0523, 8'h00); chk8(got, 8'h5A, "alias 0523");
      op(DMSD_ACC_XDATA, 1'h0, 16'hFD23, 8'h00); chk8(got, 8'h5A, "alias FD23");
      op(DMSD_ACC_XDATA, 1'h1, 16'hFFFF, 8'hC3);
      op(DMSD_ACC_XDATA, 1'h0, 16'h03FF, 8'h00); chk8(got, 8'hC3, "alias top");
      $display("external data test done");
   endtask : t_xdata
   task automatic t_record();
      do_reset();
      stk(DMSD_STK_POP, 8'h00);
      hit = stk_underflow | stk_overflow;
      @(negedge sys_clk); hit |= stk_underflow;
      chk1(hit, 1'h1, "underflow");
      do_reset();
      hit = 1'h0;
      repeat (16) begin
         stk(DMSD_STK_CALL, 8'h00); hit |= stk_overflow;
      end
      chk1(hit, 1'h0, "32 record bits fit");
      stk(DMSD_STK_PUSH, 8'h00); hit = stk_overflow;
      @(negedge sys_clk); hit |= stk_overflow;
      chk1(hit, 1'h1, "overflow");
      $display("record test done");
   endtask : t_record
   initial begin
      repeat (5000) @(posedge sys_clk);
      failures++;
      $display("mismatch at %0t: timeout", $time);
      results();
   end
   initial begin
      @(negedge sys_clk);
      do_reset();
      t_push();
      t_banks();
      t_bits();
      t_xdata();
      t_record();
      results();
   end
endmodule : tb_top
